// [core/ssac_control.sv]
`timescale 1ns/1ps
module ssac_control
    import ssac_pkg::*;
#(
    parameter int FIFO_DEPTH_P  = ssac_pkg::FIFO_DEPTH,
    parameter int CONV_CYCLES_P = ssac_pkg::CONV_CYCLES,
    parameter int INT_DIV_P     = ssac_pkg::INT_DIV
) (
    input  wire logic                                      sys_clk_i,
    input  wire logic                                      resetn_i,
    input  wire logic                                      clk_en_i,
    input  wire logic                                      convert_start_n_i,
    input  wire logic                                      cs_n_i,
    input  wire logic                                      rd_n_i,
    input  wire logic                                      wr_n_i,
    input  wire logic [ssac_pkg::SEL_W-1:0]                low_data_lines_i,
    input  wire logic [ssac_pkg::SEL_W-1:0]                hw_channel_pick_i,
    input  wire logic                                      seq_source_pick_i,
    input  wire logic                                      standby_n_i,
    input  wire logic                                      clock_source_pick_i,
    input  wire logic                                      ext_conv_clock_i,
    input  wire logic [ssac_pkg::NUM_CH*ssac_pkg::DATA_W-1:0] analog_code_i,
    output logic                                           busy_o,
    output logic                                           first_result_flag_o,
    output logic                                           eoc_n_o,
    output logic                                           hold_o,
    output logic                                           power_save_o,
    output logic [ssac_pkg::DATA_W-1:0]                    data_o,
    output logic                                           data_oe_n_o
);
    import ssac_pkg::*;

    localparam int PW = $clog2(FIFO_DEPTH_P);
    localparam int CW = $clog2(CONV_CYCLES_P + 1);
    localparam int DW = $clog2(INT_DIV_P + 1);
    localparam int SW = 8 + 2 * SEL_W + NUM_CH * DATA_W;
    localparam int RW = $bits(ssac_result_s);
    // pins at their idle levels, so no false strobe edge or bus drive follows reset
    localparam logic [SW-1:0] SYNC_IDLE = {1'b0, 3'h7, SEL_W'(0), SEL_W'(0), 1'b0, 1'b1,
                                           2'h0, (NUM_CH*DATA_W)'(0)};

    generate
        if (CONV_CYCLES_P < 1 || INT_DIV_P < 1 || FIFO_DEPTH_P < NUM_CH) begin : g_bad
            $error("ssac_control: parameter out of range");
        end
    endgenerate

    // every pin input passes two flops; stage one feeds stage two only
    logic [SW-1:0] sync1_reg, sync2_reg;
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sync1_reg <= SYNC_IDLE;
            sync2_reg <= SYNC_IDLE;
        end else if (clk_en_i) begin
            sync1_reg <= {convert_start_n_i, cs_n_i, rd_n_i, wr_n_i, low_data_lines_i,
                          hw_channel_pick_i, seq_source_pick_i, standby_n_i,
                          clock_source_pick_i, ext_conv_clock_i, analog_code_i};
            sync2_reg <= sync1_reg;
        end
    end

    logic                           s_conv, s_seq, s_standby_n, s_csel, s_ext;
    ssac_host_s                     s_host;
    logic [SEL_W-1:0]               s_hw;
    logic [NUM_CH-1:0][DATA_W-1:0]  s_code;
    assign {s_conv, s_host, s_hw, s_seq, s_standby_n, s_csel, s_ext, s_code} = sync2_reg;

    // state
    ssac_state_e                    state_reg, state_next;
    logic [SEL_W-1:0]               chsel_reg, chsel_next;
    logic [SEL_W-1:0]               seq_reg, seq_next;
    logic [NUM_CH-1:0][DATA_W-1:0]  samp_reg, samp_next;
    logic [1:0]                     chan_reg, chan_next;
    logic [CW-1:0]                  cnt_reg, cnt_next;
    logic [DW-1:0]                  div_reg, div_next;
    logic [PW-1:0]                  ptr_reg, ptr_next;
    logic                           conv_prev_reg, rd_prev_reg, wr_prev_reg, ext_prev_reg;
    logic                           busy_next, flag_next, eoc_n_next, hold_next, oe_n_next;
    logic [DATA_W-1:0]              data_next;

    // fifo hookup
    logic          fifo_flush, fifo_in_valid, fifo_in_ready, fifo_out_valid, fifo_out_ready;
    ssac_result_s  fifo_in, fifo_out;

    // edges and conversion clock
    logic conv_rise, rd_fall, wr_rise, tick, host_sel, last_chan;

    always_comb begin
        conv_rise = s_conv && !conv_prev_reg;
        rd_fall   = !s_host.rd_n && rd_prev_reg;
        wr_rise   = s_host.wr_n && !wr_prev_reg;
        host_sel  = !s_host.cs_n;
        // external clock counts rising edges, internal runs from the divider
        tick      = s_csel ? (s_ext && !ext_prev_reg)
                           : (div_reg == DW'(INT_DIV_P - 1));
        div_next  = (div_reg == DW'(INT_DIV_P - 1)) ? '0 : div_reg + 1'b1;
        last_chan = (chan_reg == 2'(NUM_CH - 1));
    end

    // sequencer, host port and output pointer
    always_comb begin
        state_next     = state_reg;
        chsel_next     = chsel_reg;
        seq_next       = seq_reg;
        samp_next      = samp_reg;
        chan_next      = chan_reg;
        cnt_next       = cnt_reg;
        ptr_next       = ptr_reg;
        busy_next      = busy_o;
        hold_next      = hold_o;
        data_next      = data_o;
        eoc_n_next     = 1'b1;
        fifo_flush     = 1'b0;
        fifo_in_valid  = 1'b0;
        fifo_out_ready = 1'b0;
        fifo_in.chan   = chan_reg;
        fifo_in.code   = samp_reg[chan_reg];

        // channel register write; a write during a read is ignored
        if (wr_rise && host_sel && s_host.rd_n) begin
            chsel_next = s_host.low_data_lines;
        end
        // read strobe falling edge pops the next result
        if (rd_fall && host_sel && s_host.wr_n && fifo_out_valid) begin
            fifo_out_ready = 1'b1;
            data_next      = fifo_out.code;
            ptr_next       = ptr_reg + 1'b1;
        end

        unique case (state_reg)
            ST_IDLE: begin
                // standby blocks new sequences; a finished sequence stays readable
                if (conv_rise && s_standby_n) begin
                    seq_next   = s_seq ? chsel_reg : s_hw;
                    samp_next  = s_code;
                    hold_next  = 1'b1;
                    busy_next  = 1'b1;
                    ptr_next   = '0;
                    fifo_flush = 1'b1;
                    chan_next  = '0;
                    cnt_next   = '0;
                    state_next = ST_CONV;
                end
            end
            ST_CONV: begin
                if (!seq_reg[chan_reg]) begin
                    // unselected channel costs one cycle and no conversion
                    if (last_chan) begin
                        busy_next  = 1'b0;
                        hold_next  = 1'b0;
                        state_next = ST_IDLE;
                    end else begin
                        chan_next = chan_reg + 1'b1;
                    end
                end else if (tick) begin
                    cnt_next = cnt_reg + 1'b1;
                    if (cnt_reg == CW'(CONV_CYCLES_P - 1)) begin
                        state_next = ST_PUSH;
                    end
                end
            end
            ST_PUSH: begin
                // a full fifo stalls the sequencer here
                fifo_in_valid = 1'b1;
                if (fifo_in_ready) begin
                    eoc_n_next = 1'b0;
                    cnt_next   = '0;
                    if (last_chan) begin
                        busy_next  = 1'b0;
                        hold_next  = 1'b0;
                        state_next = ST_IDLE;
                    end else begin
                        chan_next  = chan_reg + 1'b1;
                        state_next = ST_CONV;
                    end
                end
            end
        endcase

        flag_next = (ptr_next == '0);
        oe_n_next = !(host_sel && !s_host.rd_n);
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_reg           <= ST_IDLE;
            chsel_reg           <= CHSEL_RESET;
            seq_reg             <= '0;
            samp_reg            <= '0;
            chan_reg            <= '0;
            cnt_reg             <= '0;
            div_reg             <= '0;
            ptr_reg             <= '0;
            conv_prev_reg       <= 1'b0;
            rd_prev_reg         <= 1'b1;
            wr_prev_reg         <= 1'b1;
            ext_prev_reg        <= 1'b0;
            busy_o              <= 1'b0;
            first_result_flag_o <= 1'b1;
            eoc_n_o             <= 1'b1;
            hold_o              <= 1'b0;
            power_save_o        <= 1'b0;
            data_o              <= DATA_RESET;
            data_oe_n_o         <= 1'b1;
        end else if (clk_en_i) begin
            state_reg           <= state_next;
            chsel_reg           <= chsel_next;
            seq_reg             <= seq_next;
            samp_reg            <= samp_next;
            chan_reg            <= chan_next;
            cnt_reg             <= cnt_next;
            div_reg             <= div_next;
            ptr_reg             <= ptr_next;
            conv_prev_reg       <= s_conv;
            rd_prev_reg         <= s_host.rd_n;
            wr_prev_reg         <= s_host.wr_n;
            ext_prev_reg        <= s_ext;
            busy_o              <= busy_next;
            first_result_flag_o <= flag_next;
            eoc_n_o             <= eoc_n_next;
            hold_o              <= hold_next;
            power_save_o        <= !s_standby_n;
            data_o              <= data_next;
            data_oe_n_o         <= oe_n_next;
        end
    end

    ssac_fifo #(
        .WIDTH (RW),
        .DEPTH (FIFO_DEPTH_P)
    ) u_fifo (
        .sys_clk_i   (sys_clk_i),
        .resetn_i    (resetn_i),
        .clk_en_i    (clk_en_i),
        .flush_i     (fifo_flush),
        .in_valid_i  (fifo_in_valid),
        .in_ready_o  (fifo_in_ready),
        .in_data_i   (fifo_in),
        .out_valid_o (fifo_out_valid),
        .out_ready_i (fifo_out_ready),
        .out_data_o  (fifo_out)
    );

endmodule

// [core/ssac_fifo.sv]
`timescale 1ns/1ps
module ssac_fifo #(
    parameter int WIDTH = 14,
    parameter int DEPTH = 32
) (
    input  wire logic             sys_clk_i,
    input  wire logic             resetn_i,
    input  wire logic             clk_en_i,
    input  wire logic             flush_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic [WIDTH-1:0]      out_data_o
);
    localparam int AW = $clog2(DEPTH);

    generate
        if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_bad
            $error("ssac_fifo: DEPTH must be a power of two >= 2");
        end
    endgenerate

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr_reg, wr_ptr_next, rd_ptr_reg, rd_ptr_next;
    logic [AW:0]      count_reg, count_next;
    logic             push, pop;

    // honest full and empty come straight from the occupancy count
    assign in_ready_o  = (count_reg != (AW+1)'(DEPTH));
    assign out_valid_o = (count_reg != '0);
    assign out_data_o  = mem[rd_ptr_reg];

    // pointer and count arithmetic; flush wins over a same-cycle push or pop
    always_comb begin
        push        = in_valid_i && in_ready_o;
        pop         = out_ready_i && out_valid_o;
        wr_ptr_next = wr_ptr_reg + AW'(push);
        rd_ptr_next = rd_ptr_reg + AW'(pop);
        count_next  = count_reg + (AW+1)'(push) - (AW+1)'(pop);
        if (flush_i) begin
            wr_ptr_next = '0;
            rd_ptr_next = '0;
            count_next  = '0;
        end
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
        end else if (clk_en_i) begin
            wr_ptr_reg <= wr_ptr_next;
            rd_ptr_reg <= rd_ptr_next;
            count_reg  <= count_next;
        end
    end

    // storage has no reset, only valid entries are ever read
    always_ff @(posedge sys_clk_i) begin
        if (clk_en_i && push && !flush_i) begin
            mem[wr_ptr_reg] <= in_data_i;
        end
    end

endmodule

// [core/ssac_pkg.sv]
package ssac_pkg;

    // converter shape
    localparam int NUM_CH     = 4;
    localparam int DATA_W     = 12;
    localparam int SEL_W      = 4;
    localparam int FIFO_DEPTH = 32;

    // conversion timing
    localparam int CONV_CYCLES      = 14;
    localparam int SYS_PERIOD_NS    = 8;
    localparam int INT_CLK_PERIOD_NS = 118;
    // internal master clock as a divider of sys_clk_i, least period so round up
    localparam int INT_DIV = (INT_CLK_PERIOD_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;

    // reset values
    localparam logic [SEL_W-1:0]  CHSEL_RESET = 4'hf;
    localparam logic [DATA_W-1:0] DATA_RESET  = 12'h000;

    // host strobes and lines after synchronising
    typedef struct packed {
        logic             cs_n;
        logic             rd_n;
        logic             wr_n;
        logic [SEL_W-1:0] low_data_lines;
    } ssac_host_s;

    // one finished conversion
    typedef struct packed {
        logic [1:0]        chan;
        logic [DATA_W-1:0] code;
    } ssac_result_s;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_CONV,
        ST_PUSH
    } ssac_state_e;

endpackage

// [sim/ssac_control_bench.sv]
`timescale 1ns/1ps
module ssac_control_bench;
    import ssac_pkg::*;
    logic                     sys_clk_i, resetn_i, convert_start_n_i, src_pick, standby_n;
    logic                     clk_pick, ext_clk, ext_run, cs_n, rd_n, wr_n;
    logic                     busy, flag, eoc_n, psave, oe_n;
    logic [SEL_W-1:0]         lines, hw_pick;
    logic [NUM_CH*DATA_W-1:0] codes;
    logic [DATA_W-1:0]        data, rd_val;
    int                       n_mismatch = 0, checks_done = 0, n_eoc = 0;
    ssac_control #(.INT_DIV_P(2)) i_ssac_control (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i),
        .clk_en_i(1'b1), .convert_start_n_i(convert_start_n_i), .cs_n_i(cs_n), .rd_n_i(rd_n),
        .wr_n_i(wr_n), .low_data_lines_i(lines), .hw_channel_pick_i(hw_pick),
        .seq_source_pick_i(src_pick), .standby_n_i(standby_n), .clock_source_pick_i(clk_pick),
        .ext_conv_clock_i(ext_clk), .analog_code_i(codes), .busy_o(busy),
        .first_result_flag_o(flag), .eoc_n_o(eoc_n), .hold_o(), .power_save_o(psave),
        .data_o(data), .data_oe_n_o(oe_n));
    ssac_host_model i_ssac_host_model (.sys_clk_i(sys_clk_i), .data_i(data), .data_oe_n_i(oe_n),
        .cs_n_o(cs_n), .rd_n_o(rd_n), .wr_n_o(wr_n), .lines_o(lines));
    // external clock runs only from the second sequence through its reads and the next write, phase unrelated to sys clock
    initial begin
        sys_clk_i = 1'b0;
        forever #4 sys_clk_i = ~sys_clk_i;
    end
    initial begin
        ext_clk = 1'b0;
        forever #29 ext_clk = ext_run ? ~ext_clk : 1'b0;
    end
    always @(posedge sys_clk_i) if (eoc_n === 1'b0) n_eoc++;
    task automatic check_val(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // start, then disturb pins and codes mid-sequence; selection was captured
    task automatic run_seq(input int exp_eoc, input int lo, input int hi);
        int n;
        n_eoc = 0;
        @(posedge sys_clk_i) convert_start_n_i <= 1'b1;
        repeat (5) @(posedge sys_clk_i);
        check_val(busy, 1'b1);
        check_val(flag, 1'b1);
        convert_start_n_i <= 1'b0;
        codes <= ~codes;
        hw_pick <= ~hw_pick;
        n = 0;
        while (busy !== 1'b0 && n < 3000) begin
            @(posedge sys_clk_i);
            n++;
        end
        repeat (2) @(posedge sys_clk_i);
        check_val(DATA_W'(n_eoc), DATA_W'(exp_eoc));
        check_val(DATA_W'(n >= lo && n <= hi), 12'h001);
    endtask
    task automatic read_chk(input logic [DATA_W-1:0] exp);
        i_ssac_host_model.read_word(rd_val);
        check_val(rd_val, exp);
    endtask
    initial begin
        {resetn_i, convert_start_n_i, src_pick, clk_pick, ext_run} = 5'h00;
        standby_n = 1'b1;
        hw_pick = 4'b0101;
        codes = {12'h444, 12'h333, 12'h222, 12'h111};
        repeat (6) @(posedge sys_clk_i);
        resetn_i <= 1'b1;
        repeat (6) @(posedge sys_clk_i);
        check_val({busy, flag, eoc_n, oe_n}, 4'h7);
        check_val(data, 12'h000);
        run_seq(2, 40, 80);
        read_chk(12'h111);
        check_val(flag, 1'b0);
        read_chk(12'h333);
        read_chk(12'h333);
        $display("test pin selection done");
        i_ssac_host_model.write_sel(4'b1010, 1'b1);
        src_pick <= 1'b1;
        clk_pick <= 1'b1;
        ext_run <= 1'b1;
        hw_pick <= 4'b0001;
        run_seq(2, 150, 300);
        read_chk(12'hddd);
        read_chk(12'hbbb);
        $display("test register selection done");
        i_ssac_host_model.write_sel(4'b0001, 1'b0);
        ext_run <= 1'b0;
        clk_pick <= 1'b0;
        standby_n <= 1'b0;
        repeat (6) @(posedge sys_clk_i);
        check_val(psave, 1'b1);
        convert_start_n_i <= 1'b1;
        repeat (6) @(posedge sys_clk_i);
        check_val(busy, 1'b0);
        convert_start_n_i <= 1'b0;
        standby_n <= 1'b1;
        repeat (6) @(posedge sys_clk_i);
        run_seq(2, 40, 80);
        read_chk(12'h222);
        read_chk(12'h444);
        $display("test refusals done");
        end_sim();
    end
    initial begin
        #200000;
        n_mismatch++;
        $display("watchdog expired");
        end_sim();
    end
endmodule
bind ssac_control ssac_control_monitor #(.CONV_CYCLES_P(CONV_CYCLES_P)) i_ssac_control_monitor (
    .sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .convert_start_n_i(convert_start_n_i),
    .cs_n_i(cs_n_i), .rd_n_i(rd_n_i), .standby_n_i(standby_n_i), .busy_o(busy_o),
    .first_result_flag_o(first_result_flag_o), .eoc_n_o(eoc_n_o), .hold_o(hold_o),
    .power_save_o(power_save_o), .data_o(data_o), .data_oe_n_o(data_oe_n_o));

// [sim/ssac_control_monitor.sv]
`timescale 1ns/1ps
module ssac_control_monitor #(
    parameter int CONV_CYCLES_P = 14
) (
    input wire logic                        sys_clk_i,
    input wire logic                        resetn_i,
    input wire logic                        convert_start_n_i,
    input wire logic                        cs_n_i,
    input wire logic                        rd_n_i,
    input wire logic                        standby_n_i,
    input wire logic                        busy_o,
    input wire logic                        first_result_flag_o,
    input wire logic                        eoc_n_o,
    input wire logic                        hold_o,
    input wire logic                        power_save_o,
    input wire logic [ssac_pkg::DATA_W-1:0] data_o,
    input wire logic                        data_oe_n_o
);
    import ssac_pkg::*;
    logic [2:0] settle_reg, settle_next;
    logic [7:0] gap_reg, gap_next;
    // synchronisers load idle levels on reset, so pin relations wait a few edges
    always_comb begin
        settle_next = (settle_reg == 3'h5) ? settle_reg : settle_reg + 3'h1;
        gap_next = (!eoc_n_o || !busy_o) ? 8'h00 : gap_reg + {7'h00, gap_reg != 8'hff};
    end
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            settle_reg <= 3'h0;
            gap_reg <= 8'h00;
        end else begin
            settle_reg <= settle_next;
            gap_reg <= gap_next;
        end
    end
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!resetn_i);
    busy_start_a: assert property ($rose(busy_o) |->
        $past(convert_start_n_i, 2) && !$past(convert_start_n_i, 5)) else $error("busy rose unasked");
    hold_busy_a: assert property (hold_o == busy_o) else $error("hold differs from busy");
    flag_start_a: assert property ($rose(busy_o) |-> first_result_flag_o)
        else $error("flag low at start");
    eoc_one_a: assert property ($fell(eoc_n_o) |=> eoc_n_o) else $error("eoc too long");
    eoc_busy_a: assert property (!eoc_n_o |-> $past(busy_o)) else $error("eoc while idle");
    conv_span_a: assert property ($fell(eoc_n_o) |-> gap_reg >= 8'(CONV_CYCLES_P - 1))
        else $error("conversion too short");
    oe_level_a: assert property (settle_reg == 3'h5 |->
        data_oe_n_o == $past(cs_n_i || rd_n_i, 3)) else $error("output enable wrong");
    data_pop_a: assert property (settle_reg == 3'h5 && $changed(data_o) |->
        $past(!cs_n_i && !rd_n_i, 3) && $past(rd_n_i, 4)) else $error("data changed unread");
    power_save_a: assert property (settle_reg == 3'h5 |->
        power_save_o == !$past(standby_n_i, 3)) else $error("power save wrong");
    cover property ($rose(busy_o));
    cover property (!eoc_n_o);
    cover property (!data_oe_n_o);
endmodule

// [sim/ssac_host_model.sv]
`timescale 1ns/1ps
module ssac_host_model (
    input  wire logic                        sys_clk_i,
    input  wire logic [ssac_pkg::DATA_W-1:0] data_i,
    input  wire logic                        data_oe_n_i,
    output logic                             cs_n_o,
    output logic                             rd_n_o,
    output logic                             wr_n_o,
    output logic [ssac_pkg::SEL_W-1:0]       lines_o
);
    import ssac_pkg::*;
    initial begin
        cs_n_o = 1'b1;
        rd_n_o = 1'b1;
        wr_n_o = 1'b1;
        lines_o = 4'h0;
    end
    // strobe rises while select still held; lines then show a changed pattern
    task automatic write_sel(input logic [SEL_W-1:0] val, input logic sel);
        @(posedge sys_clk_i);
        cs_n_o <= !sel;
        wr_n_o <= 1'b0;
        lines_o <= val;
        repeat (4) @(posedge sys_clk_i);
        wr_n_o <= 1'b1;
        repeat (4) @(posedge sys_clk_i);
        cs_n_o <= 1'b1;
        lines_o <= ~val;
        repeat (2) @(posedge sys_clk_i);
    endtask
    // write strobe is never touched here, it stays high through the read
    task automatic read_word(output logic [DATA_W-1:0] val);
        int n;
        @(posedge sys_clk_i);
        cs_n_o <= 1'b0;
        rd_n_o <= 1'b0;
        n = 0;
        do begin
            @(posedge sys_clk_i);
            n++;
        end while (data_oe_n_i !== 1'b0 && n < 8);
        val = (data_oe_n_i === 1'b0) ? data_i : 'x;
        rd_n_o <= 1'b1;
        @(posedge sys_clk_i);
        cs_n_o <= 1'b1;
        repeat (5) @(posedge sys_clk_i);
    endtask
endmodule
